// ### rtl/fobr_pkg.sv
// Constants, register map and address decode for the observer readback bank.
// Assumes a single 20 MHz clock domain shared by the algorithm engine and the
// serial access logic that presents host reads and writes.
package fobr_pkg;

  // Bus and data widths
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int GAIN_W   = 16;
  localparam int NUM_REGS = 10;
  localparam int IDX_W    = 4;

  // Fixed-point scaling, for software reference only
  localparam int FRAC_BITS    = 27;
  localparam int FULL_SCALE_V = 60;
  localparam int CURRENT_DIV  = 8;

  // Register offsets as printed
  localparam logic [ADDR_W-1:0] OFS_BUS_VOLTAGE_SCALE   = 12'h472;
  localparam logic [ADDR_W-1:0] OFS_SUPPLY_RAIL_LEVEL   = 12'h474;
  localparam logic [ADDR_W-1:0] OFS_PHASE_A_LEVEL       = 12'h47A;
  localparam logic [ADDR_W-1:0] OFS_PHASE_B_LEVEL       = 12'h47C;
  localparam logic [ADDR_W-1:0] OFS_PHASE_C_LEVEL       = 12'h47E;
  localparam logic [ADDR_W-1:0] OFS_ROTOR_ANGLE_SINE    = 12'h4B6;
  localparam logic [ADDR_W-1:0] OFS_ROTOR_ANGLE_COSINE  = 12'h4B8;
  localparam logic [ADDR_W-1:0] OFS_STAT_CURRENT_REAL   = 12'h4D2;
  localparam logic [ADDR_W-1:0] OFS_STAT_CURRENT_IMAG   = 12'h4D4;
  localparam logic [ADDR_W-1:0] OFS_STAT_VOLTAGE_REAL   = 12'h4D6;

  // Slot indices inside the bank
  localparam logic [IDX_W-1:0] IDX_BUS_VOLTAGE_SCALE  = 4'h0;
  localparam logic [IDX_W-1:0] IDX_SUPPLY_RAIL_LEVEL  = 4'h1;
  localparam logic [IDX_W-1:0] IDX_PHASE_A_LEVEL      = 4'h2;
  localparam logic [IDX_W-1:0] IDX_PHASE_B_LEVEL      = 4'h3;
  localparam logic [IDX_W-1:0] IDX_PHASE_C_LEVEL      = 4'h4;
  localparam logic [IDX_W-1:0] IDX_ROTOR_ANGLE_SINE   = 4'h5;
  localparam logic [IDX_W-1:0] IDX_ROTOR_ANGLE_COSINE = 4'h6;
  localparam logic [IDX_W-1:0] IDX_STAT_CURRENT_REAL  = 4'h7;
  localparam logic [IDX_W-1:0] IDX_STAT_CURRENT_IMAG  = 4'h8;
  localparam logic [IDX_W-1:0] IDX_STAT_VOLTAGE_REAL  = 4'h9;

  // Bus voltage scale codes and reset values
  localparam logic [GAIN_W-1:0] SCALE_60V      = 16'h0000;
  localparam logic [GAIN_W-1:0] SCALE_30V      = 16'h0001;
  localparam logic [GAIN_W-1:0] SCALE_15V      = 16'h0002;
  localparam logic [GAIN_W-1:0] SCALE_RST      = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_RST       = 32'h00000000;
  localparam logic [DATA_W-1:0] UNMAPPED_VALUE = 32'h00000000;

  typedef logic [IDX_W-1:0] fobr_idx_t;

  // Address to slot decode; shared by the engine and host paths
  function automatic logic fobr_decode(input  logic [ADDR_W-1:0] addr,
                                       output fobr_idx_t         idx);
    logic hit;
    hit = 1'b1;
    idx = IDX_BUS_VOLTAGE_SCALE;
    unique case (addr)
      OFS_BUS_VOLTAGE_SCALE:  idx = IDX_BUS_VOLTAGE_SCALE;
      OFS_SUPPLY_RAIL_LEVEL:  idx = IDX_SUPPLY_RAIL_LEVEL;
      OFS_PHASE_A_LEVEL:      idx = IDX_PHASE_A_LEVEL;
      OFS_PHASE_B_LEVEL:      idx = IDX_PHASE_B_LEVEL;
      OFS_PHASE_C_LEVEL:      idx = IDX_PHASE_C_LEVEL;
      OFS_ROTOR_ANGLE_SINE:   idx = IDX_ROTOR_ANGLE_SINE;
      OFS_ROTOR_ANGLE_COSINE: idx = IDX_ROTOR_ANGLE_COSINE;
      OFS_STAT_CURRENT_REAL:  idx = IDX_STAT_CURRENT_REAL;
      OFS_STAT_CURRENT_IMAG:  idx = IDX_STAT_CURRENT_IMAG;
      OFS_STAT_VOLTAGE_REAL:  idx = IDX_STAT_VOLTAGE_REAL;
      default:                hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

// ### rtl/fobr_slot.sv
// One readback storage slot, loaded only by the algorithm engine.
// Assumes the load strobe is already qualified by decode and acceptance.
`timescale 1ns/1ps
`default_nettype none
module fobr_slot #(
  parameter int          WIDTH     = 32,
  parameter logic [31:0] RESET_VAL = 32'h00000000
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  import fobr_pkg::*;

  logic [WIDTH-1:0] val_r;
  logic [WIDTH-1:0] val_nxt;

  // Only the engine path can change the slot
  always_comb
  begin
    val_nxt = val_r;
    if (load_i)
    begin
      val_nxt = d_i;
    end
  end

  // Reset wins over the clock enable so a frozen bank still clears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      val_r <= RESET_VAL[WIDTH-1:0];
    end
    else if (ce_i)
    begin
      val_r <= val_nxt;
    end
  end

  assign q_o = val_r;

endmodule
`default_nettype wire

// ### rtl/fobr_bank.sv
// Observer readback bank: field-oriented control quantities for host reads.
// Assumes engine updates and host accesses arrive on clk_i from logic in the
// same domain, one request per cycle per port.
`timescale 1ns/1ps
`default_nettype none
module fobr_bank (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  // Algorithm engine update port
  input  wire logic                          upd_valid_i,
  input  wire logic [fobr_pkg::ADDR_W-1:0]   upd_addr_i,
  input  wire logic [fobr_pkg::DATA_W-1:0]   upd_data_i,
  input  wire logic                          spin_detection_phase_i,
  output logic                               upd_ok_o,
  output logic                               upd_reject_o,
  // Host register access port
  input  wire logic                          host_rd_i,
  input  wire logic                          host_wr_i,
  input  wire logic [fobr_pkg::ADDR_W-1:0]   host_addr_i,
  input  wire logic [fobr_pkg::DATA_W-1:0]   host_wdata_i,
  output logic      [fobr_pkg::DATA_W-1:0]   host_rdata_o,
  output logic                               host_rvalid_o,
  output logic                               host_err_o,
  output logic                               host_wr_ignored_o
);
  import fobr_pkg::*;

  fobr_idx_t        upd_idx;
  logic             upd_hit;
  logic             upd_accept;
  fobr_idx_t        rd_idx;
  logic             rd_hit;
  logic [DATA_W-1:0] slot_word [NUM_REGS];

  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              rvalid_r;
  logic              rvalid_nxt;
  logic              err_r;
  logic              err_nxt;
  logic              wr_ign_r;
  logic              wr_ign_nxt;

  // Engine update qualification
  always_comb
  begin
    upd_idx    = IDX_BUS_VOLTAGE_SCALE;
    upd_hit    = fobr_decode(upd_addr_i, upd_idx);
    upd_accept = upd_valid_i && upd_hit;
    if (upd_idx == IDX_BUS_VOLTAGE_SCALE)
    begin
      // Only the three defined scale codes are stored
      if (upd_data_i[DATA_W-1:GAIN_W] != '0 ||
          upd_data_i[GAIN_W-1:0] > SCALE_15V)
      begin
        upd_accept = 1'b0;
      end
    end
    if (upd_idx == IDX_PHASE_A_LEVEL || upd_idx == IDX_PHASE_B_LEVEL ||
        upd_idx == IDX_PHASE_C_LEVEL)
    begin
      // Terminal levels are a snapshot of spin detection only
      if (!spin_detection_phase_i)
      begin
        upd_accept = 1'b0;
      end
    end
  end

  // Handshake answers to the engine; combinational by design
  assign upd_ok_o     = upd_accept && ce_i;
  assign upd_reject_o = upd_valid_i && !upd_accept && ce_i;

  // Storage slots; the scale slot is narrow, the rest are full words
  generate
    for (genvar i = 0; i < NUM_REGS; i++)
    begin : g_slot
      if (i == int'(IDX_BUS_VOLTAGE_SCALE))
      begin : g_scale
        logic [GAIN_W-1:0] q;
        fobr_slot #(
          .WIDTH     (GAIN_W),
          .RESET_VAL (DATA_W'(SCALE_RST))
        ) u_slot (
          .clk_i  (clk_i),
          .rst_i  (rst_i),
          .ce_i   (ce_i),
          .load_i (upd_accept && upd_idx == IDX_BUS_VOLTAGE_SCALE),
          .d_i    (upd_data_i[GAIN_W-1:0]),
          .q_o    (q)
        );
        // Upper bits of the narrow readback read as zero
        assign slot_word[i] = {{(DATA_W-GAIN_W){1'b0}}, q};
      end
      else
      begin : g_word
        logic [DATA_W-1:0] q;
        fobr_slot #(
          .WIDTH     (DATA_W),
          .RESET_VAL (WORD_RST)
        ) u_slot (
          .clk_i  (clk_i),
          .rst_i  (rst_i),
          .ce_i   (ce_i),
          .load_i (upd_accept && upd_idx == IDX_W'(i)),
          .d_i    (upd_data_i),
          .q_o    (q)
        );
        assign slot_word[i] = q;
      end
    end
  endgenerate

  // Host access: whole word captured in one edge, writes only flagged
  always_comb
  begin
    rd_idx     = IDX_BUS_VOLTAGE_SCALE;
    rd_hit     = fobr_decode(host_addr_i, rd_idx);
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    err_nxt    = 1'b0;
    wr_ign_nxt = host_wr_i;
    if (host_rd_i)
    begin
      rvalid_nxt = 1'b1;
      // Taken from the stored value, never mid-update, so no torn words
      rdata_nxt  = rd_hit ? slot_word[rd_idx] : UNMAPPED_VALUE;
      err_nxt    = !rd_hit;
    end
  end

  // Host answer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_r  <= WORD_RST;
      rvalid_r <= 1'b0;
      err_r    <= 1'b0;
      wr_ign_r <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r    <= err_nxt;
      wr_ign_r <= wr_ign_nxt;
    end
  end

  assign host_rdata_o      = rdata_r;
  assign host_rvalid_o     = rvalid_r;
  assign host_err_o        = err_r;
  assign host_wr_ignored_o = wr_ign_r;

endmodule
`default_nettype wire

// ### bench/fobr_bank_chk.sv
// Port checker for the observer readback bank.
// Assumes one clk_i domain and a bind onto fobr_bank.
`timescale 1ns/1ps
`default_nettype none
module fobr_bank_chk
  import fobr_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire logic              upd_valid_i,
  input wire logic [ADDR_W-1:0] upd_addr_i,
  input wire logic [DATA_W-1:0] upd_data_i,
  input wire logic              spin_detection_phase_i,
  input wire logic              upd_ok_o,
  input wire logic              upd_reject_o,
  input wire logic              host_rd_i,
  input wire logic              host_wr_i,
  input wire logic [ADDR_W-1:0] host_addr_i,
  input wire logic [DATA_W-1:0] host_wdata_i,
  input wire logic [DATA_W-1:0] host_rdata_o,
  input wire logic              host_rvalid_o,
  input wire logic              host_err_o,
  input wire logic              host_wr_ignored_o
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_rd_answer: assert property (host_rd_i && ce_i |=> host_rvalid_o)
    else $error("read not answered next cycle");
  chk_rd_spurious: assert property (ce_i && !host_rd_i |=> !host_rvalid_o)
    else $error("read answer without request");
  chk_wr_ignored: assert property (host_wr_i && ce_i |=> host_wr_ignored_o)
    else $error("write not flagged as ignored");
  chk_err_zero: assert property (host_rvalid_o && host_err_o |-> host_rdata_o == 32'h0)
    else $error("unmapped read returned data");
  chk_rdata_hold: assert property (!host_rvalid_o |-> $stable(host_rdata_o))
    else $error("read data moved between reads");
  chk_scale_width: assert property (host_rvalid_o && !host_err_o
    && $past(host_addr_i) == OFS_BUS_VOLTAGE_SCALE |-> host_rdata_o[31:16] == 16'h0)
    else $error("scale readback wider than 16 bits");
  chk_ok_cause: assert property (upd_ok_o |-> upd_valid_i && ce_i && !upd_reject_o)
    else $error("update accepted without request");
  chk_rej_cause: assert property (upd_reject_o |-> upd_valid_i && ce_i)
    else $error("update refused without request");
  chk_scale_code: assert property (upd_valid_i && ce_i
    && upd_addr_i == OFS_BUS_VOLTAGE_SCALE && upd_data_i > 32'h2 |-> upd_reject_o)
    else $error("illegal scale code accepted");
  chk_phase_gate: assert property (upd_valid_i && ce_i && !spin_detection_phase_i
    && (upd_addr_i == OFS_PHASE_A_LEVEL || upd_addr_i == OFS_PHASE_B_LEVEL
    || upd_addr_i == OFS_PHASE_C_LEVEL) |-> upd_reject_o)
    else $error("phase level stored outside spin detection");
endmodule
bind fobr_bank fobr_bank_chk i_fobr_bank_chk (.clk_i, .rst_i, .ce_i, .upd_valid_i,
  .upd_addr_i, .upd_data_i, .spin_detection_phase_i, .upd_ok_o, .upd_reject_o, .host_rd_i,
  .host_wr_i, .host_addr_i, .host_wdata_i, .host_rdata_o, .host_rvalid_o, .host_err_o,
  .host_wr_ignored_o);
`default_nettype wire

// ### bench/fobr_host_model.sv
// Host side model: keeps the last read answer as the serial host would.
// Assumes the bank's clk_i and its one-cycle answer pulse.
`timescale 1ns/1ps
`default_nettype none
module fobr_host_model (
  input  wire logic        clk_i,
  input  wire logic        rvalid_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        err_i,
  output logic      [31:0] cap_data_o,
  output logic             cap_err_o
);
  // Whole word taken on the pulse only, so a torn word would show
  always_ff @(posedge clk_i)
  begin
    if (rvalid_i)
    begin
      cap_data_o <= rdata_i;
      cap_err_o  <= err_i;
    end
  end
endmodule
`default_nettype wire

// ### bench/fobr_bank_bench.sv
// Self-checking bench for the observer readback bank.
// Assumes fobr_pkg, the design, checker and host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module fobr_bank_bench;
  import fobr_pkg::*;
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic        s;
    logic        ok;
    logic [31:0] rb;
  } fobr_row_t;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, upd_valid_i = 1'b0, host_rd_i = 1'b0;
  logic        spin_detection_phase_i = 1'b0, host_wr_i = 1'b0, rd_e, cap_err;
  logic        upd_ok_o, upd_reject_o, host_rvalid_o, host_err_o, host_wr_ignored_o;
  logic [11:0] upd_addr_i = 12'h0, host_addr_i = 12'h0;
  logic [31:0] upd_data_i = 32'h0, host_wdata_i = 32'h0, host_rdata_o, cap_data, rd_d;
  int          n_errors = 0, num_checks = 0;
  // Address, data, spin, accepted, read-back; order matters, scale ends non-zero
  fobr_row_t rows [16] = '{'{12'h474, 32'h11223344, 1'b0, 1'b1, 32'h11223344},
    '{12'h472, 32'h2, 1'b0, 1'b1, 32'h2}, '{12'h472, 32'h3, 1'b0, 1'b0, 32'h2},
    '{12'h472, 32'h10001, 1'b0, 1'b0, 32'h2}, '{12'h472, 32'h0, 1'b0, 1'b1, 32'h0},
    '{12'h472, 32'h1, 1'b0, 1'b1, 32'h1}, '{12'h47A, 32'hA5A5A5A5, 1'b0, 1'b0, 32'h0},
    '{12'h47A, 32'hA5A5A5A5, 1'b1, 1'b1, 32'hA5A5A5A5},
    '{12'h47C, 32'h5A5A0001, 1'b1, 1'b1, 32'h5A5A0001},
    '{12'h47E, 32'h80000000, 1'b1, 1'b1, 32'h80000000},
    '{12'h4B6, 32'h08000000, 1'b0, 1'b1, 32'h08000000},
    '{12'h4B8, 32'hF8000000, 1'b0, 1'b1, 32'hF8000000},
    '{12'h4D2, 32'h7FFFFFFF, 1'b0, 1'b1, 32'h7FFFFFFF},
    '{12'h4D4, 32'h00000001, 1'b0, 1'b1, 32'h00000001},
    '{12'h4D6, 32'hFFFFFFFF, 1'b0, 1'b1, 32'hFFFFFFFF},
    '{12'h476, 32'h12345678, 1'b0, 1'b0, 32'h0}};
  fobr_bank i_fobr_bank (.clk_i, .rst_i, .ce_i, .upd_valid_i, .upd_addr_i, .upd_data_i,
    .spin_detection_phase_i, .upd_ok_o, .upd_reject_o, .host_rd_i, .host_wr_i, .host_addr_i,
    .host_wdata_i, .host_rdata_o, .host_rvalid_o, .host_err_o, .host_wr_ignored_o);
  fobr_host_model i_fobr_host_model (.clk_i, .rvalid_i(host_rvalid_o), .rdata_i(host_rdata_o),
    .err_i(host_err_o), .cap_data_o(cap_data), .cap_err_o(cap_err));
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Engine update; answer is combinational, so look once inputs settle
  task automatic upd(input fobr_row_t r);
    @(posedge clk_i);
    upd_valid_i <= 1'b1;
    upd_addr_i <= r.a;
    upd_data_i <= r.d;
    spin_detection_phase_i <= r.s;
    #1 chk({upd_ok_o, upd_reject_o}, {r.ok, ~r.ok});
    @(posedge clk_i);
    upd_valid_i <= 1'b0;
    spin_detection_phase_i <= 1'b0;
  endtask
  // Host read; the model holds the answer one edge after the pulse
  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    host_rd_i <= 1'b1;
    host_addr_i <= a;
    @(posedge clk_i);
    host_rd_i <= 1'b0;
    @(posedge clk_i);
    #1 rd_d = cap_data;
    rd_e = cap_err;
  endtask
  // Watchdog well beyond the roughly 150 cycles the run needs
  initial
  begin
    #100000;
    n_errors++;
    final_report;
  end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      upd(rows[i]);
      rd(rows[i].a);
      chk(rd_d, rows[i].rb);
      chk({31'h0, rd_e}, {31'h0, rows[i].a == 12'h476});
    end
    // Update and read of one slot in the same cycle: old value wins
    @(posedge clk_i);
    upd_valid_i <= 1'b1;
    upd_addr_i <= OFS_SUPPLY_RAIL_LEVEL;
    upd_data_i <= 32'hCAFE0001;
    host_rd_i <= 1'b1;
    host_addr_i <= OFS_SUPPLY_RAIL_LEVEL;
    @(posedge clk_i);
    // Frozen update carries new data, so a leak past ce_i would show
    host_rd_i <= 1'b0;
    ce_i <= 1'b0;
    upd_data_i <= 32'h0BAD0BAD;
    @(posedge clk_i);
    #1 chk(cap_data, 32'h11223344);
    chk({upd_ok_o, upd_reject_o}, 2'h0);
    // Frozen update above must not land; host write must not either
    @(posedge clk_i);
    ce_i <= 1'b1;
    upd_valid_i <= 1'b0;
    host_wr_i <= 1'b1;
    host_wdata_i <= 32'hDEADBEEF;
    @(posedge clk_i);
    host_wr_i <= 1'b0;
    #1 chk({31'h0, host_wr_ignored_o}, 32'h1);
    rd(OFS_SUPPLY_RAIL_LEVEL);
    chk(rd_d, 32'hCAFE0001);
    // Mid-run reset clears every slot and every answer flag
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk(host_rdata_o, 32'h0);
    chk({29'h0, host_rvalid_o, host_err_o, host_wr_ignored_o}, 32'h0);
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk(rd_d, 32'h0);
    end
    final_report;
  end
endmodule
`default_nettype wire
